// ==== verilog/qdl_host.sv ====
// Functional notes
// R1: device has input and converter latch per channel
// R2: device latches are level sensitive
// R3: select low plus strobe low loads channel
// R4: update low plus strobe low copies all
// R5: reset clears converter latches only
// R6: write all four channels before update
// R7: data lines are positive-true binary
// R8: offset binary, 800 is zero
// R9: invert msb for two's complement data
// R10: strobe is the closing edge
// R11: reset forces bipolar zero asynchronously
// R12: strobe high changes no latch
// R13: all low makes everything transparent
// R14: reset loads 800 until update
`timescale 1ns/1ns
`default_nettype none
`include "qdl_cfg.svh"
module qdl_host #(
	parameter int NUM_CH = `QDL_NUM_CH,
	parameter int SETUP_CYC = `QDL_SETUP_CYC,
	parameter int STROBE_CYC = `QDL_STROBE_CYC,
	parameter int HOLD_CYC = `QDL_HOLD_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic twos_comp,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [1:0] wr_chan,
	input wire logic [11:0] wr_sample,
	input wire logic upd_valid,
	output logic upd_ready,
	input wire logic dev_reset_req,
	output logic dev_reset_n,
	output logic [3:0] loaded,
	output logic [3:0] channel_select_n,
	output logic update_all_n,
	output logic wr_n,
	output logic [11:0] data_out
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		qdl_pkg::qdl_state_e st;
		qdl_pkg::qdl_cnt_t cnt;
		logic is_upd;
		logic [3:0] sel_n;
		logic upd_n;
		logic wr_n;
		logic [11:0] data;
		logic [3:0] loaded;
		logic rst_n;
	} qdl_host_s;

	qdl_host_s s_q;
	qdl_host_s s_d;
	logic [11:0] code;
	qdl_pins_if pins();

	function automatic qdl_pkg::qdl_cnt_t cyc(input int n);
		cyc = qdl_pkg::qdl_cnt_t'(n - 1);
	endfunction

	function automatic logic [3:0] one_low(input logic [1:0] ch);
		one_low = ~(4'h1 << ch);
	endfunction

	function automatic logic cnt_done(input qdl_pkg::qdl_cnt_t c);
		cnt_done = (c == 8'h00);
	endfunction

	function automatic qdl_pkg::qdl_cnt_t cnt_dec(input qdl_pkg::qdl_cnt_t c);
		cnt_dec = c - 8'h01;
	endfunction

	// common part of accepting a write or an update request
	function automatic qdl_host_s start_xfer(input qdl_host_s cur, input logic upd);
		start_xfer = cur;
		start_xfer.is_upd = upd;
		start_xfer.cnt = cyc(SETUP_CYC);
		start_xfer.st = qdl_pkg::QDL_SETUP;
	endfunction

	// every pin idle; device reset follows ours so outputs return to zero code (see R11, R14)
	function automatic qdl_host_s reset_state();
		reset_state.st = qdl_pkg::QDL_IDLE;
		reset_state.cnt = `QDL_CNT_RST;
		reset_state.is_upd = 1'b0;
		reset_state.sel_n = `QDL_SEL_IDLE;
		reset_state.upd_n = 1'b1;
		reset_state.wr_n = 1'b1;
		reset_state.data = `QDL_DATA_RST;
		reset_state.loaded = 4'h0;
		reset_state.rst_n = 1'b0;
	endfunction

	qdl_code_fmt u_fmt (
		.twos_comp(twos_comp),
		.sample(wr_sample),
		.code(code)
	);

	////////////////////////////////////////////////////////////////////////
	logic idle;
	logic all_loaded;
	assign idle = (s_q.st == qdl_pkg::QDL_IDLE) && s_q.rst_n;
	assign all_loaded = &s_q.loaded;
	assign wr_ready = idle && !dev_reset_req;
	// unknown first-rank data must not reach outputs (see R6)
	assign upd_ready = idle && !dev_reset_req && !wr_valid && all_loaded;

	always_comb begin
		s_d = s_q;
		s_d.rst_n = 1'b1;
		case (s_q.st)
			qdl_pkg::QDL_IDLE: begin
				if (dev_reset_req) begin
					// converter latches go to zero, input latches stay stale (see R5)
					s_d.rst_n = 1'b0;
					s_d.loaded = 4'h0;
				end else if (wr_valid && wr_ready) begin
					s_d = start_xfer(s_d, 1'b0);
					// positive-true code drives the lines as is (see R7)
					s_d.data = code;
					s_d.sel_n = one_low(wr_chan);
				end else if (upd_valid && upd_ready) begin
					s_d = start_xfer(s_d, 1'b1);
					s_d.upd_n = 1'b0;
				end
			end
			qdl_pkg::QDL_SETUP: begin
				if (cnt_done(s_q.cnt)) begin
					// select and update settle first: their path is slow (see R10)
					s_d.wr_n = 1'b0;
					s_d.cnt = cyc(STROBE_CYC);
					s_d.st = qdl_pkg::QDL_STROBE;
				end else begin
					s_d.cnt = cnt_dec(s_q.cnt);
				end
			end
			qdl_pkg::QDL_STROBE: begin
				if (cnt_done(s_q.cnt)) begin
					// strobe rising edge closes the latch (see R3, R4, R10)
					s_d.wr_n = 1'b1;
					s_d.cnt = cyc(HOLD_CYC);
					s_d.st = qdl_pkg::QDL_HOLD;
					if (!s_q.is_upd) begin
						s_d.loaded = s_q.loaded | ~s_q.sel_n;
					end
				end else begin
					s_d.cnt = cnt_dec(s_q.cnt);
				end
			end
			qdl_pkg::QDL_HOLD: begin
				if (cnt_done(s_q.cnt)) begin
					// only one select or update low at a time, never all (see R12, R13)
					s_d.sel_n = `QDL_SEL_IDLE;
					s_d.upd_n = 1'b1;
					s_d.st = qdl_pkg::QDL_DONE;
				end else begin
					s_d.cnt = cnt_dec(s_q.cnt);
				end
			end
			qdl_pkg::QDL_DONE: begin
				s_d.st = qdl_pkg::QDL_IDLE;
			end
			default: begin
				s_d.st = qdl_pkg::QDL_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= reset_state();
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign pins.wr_n = s_q.wr_n;
	assign pins.update_n = s_q.upd_n;
	assign pins.sel_n = s_q.sel_n;
	assign pins.data = s_q.data;
	assign wr_n = pins.wr_n;
	assign update_all_n = pins.update_n;
	assign channel_select_n = pins.sel_n;
	assign data_out = pins.data;
	assign dev_reset_n = s_q.rst_n;
	assign loaded = s_q.loaded;
endmodule
`default_nettype wire

// ==== verilog/qdl_cfg.svh ====
`ifndef QDL_CFG_SVH
`define QDL_CFG_SVH

// code width and channel count
`define QDL_CODE_W 12
`define QDL_NUM_CH 4
// bipolar zero code, converter latch value after reset
`define QDL_BIPOLAR_ZERO 12'h800
// host pin and state values held during reset
`define QDL_SEL_IDLE 4'hf
`define QDL_DATA_RST 12'h000
`define QDL_CNT_RST 8'h00
// offset-binary msb position
`define QDL_MSB_POS 11
// bus timing in ns, cycles at 4 ns clock period
`define QDL_CLK_NS 4
`define QDL_SETUP_NS 20
`define QDL_STROBE_NS 40
`define QDL_HOLD_NS 12
`define QDL_SETUP_CYC ((`QDL_SETUP_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_STROBE_CYC ((`QDL_STROBE_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_HOLD_CYC ((`QDL_HOLD_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)

`endif

// ==== verilog/qdl_pkg.sv ====
package qdl_pkg;
	typedef enum logic [4:0] {
		QDL_IDLE = 5'b00001,
		QDL_SETUP = 5'b00010,
		QDL_STROBE = 5'b00100,
		QDL_HOLD = 5'b01000,
		QDL_DONE = 5'b10000
	} qdl_state_e;
	typedef logic [11:0] qdl_code_t;
	typedef logic [7:0] qdl_cnt_t;
endpackage

// ==== verilog/qdl_pins_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface qdl_pins_if;
	logic wr_n;
	logic update_n;
	logic [3:0] sel_n;
	logic [11:0] data;
	modport drv(output wr_n, output update_n, output sel_n, output data);
	modport mon(input wr_n, input update_n, input sel_n, input data);
endinterface
`default_nettype wire

// ==== verilog/qdl_code_fmt.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "qdl_cfg.svh"
// converts a host sample into the converter's positive-true offset-binary code
module qdl_code_fmt (
	input wire logic twos_comp,
	input wire qdl_pkg::qdl_code_t sample,
	output logic [11:0] code
);
	always_comb begin
		code = sample;
		// two's complement maps onto offset binary by flipping the msb (see R9)
		if (twos_comp) begin
			code[`QDL_MSB_POS] = ~sample[`QDL_MSB_POS];
		end
	end
endmodule
`default_nettype wire

// ==== verification/qdl_host_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module qdl_host_properties (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic twos_comp,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [11:0] wr_sample,
	input wire logic [3:0] loaded,
	input wire logic [3:0] channel_select_n,
	input wire logic update_all_n,
	input wire logic wr_n,
	input wire logic [11:0] data_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	one_target_a: assert property ($fell(wr_n) |->
		(update_all_n && $onehot(~channel_select_n)) || (!update_all_n && &channel_select_n))
		else $error("strobe without single target");
	no_idle_strobe_a: assert property (!wr_n |-> !(update_all_n && &channel_select_n))
		else $error("strobe with nothing selected");
	strobe_width_a: assert property ($fell(wr_n) |-> !wr_n[*8])
		else $error("strobe too short");
	strobe_hold_a: assert property (!wr_n |=> $stable(data_out) && $stable(channel_select_n))
		else $error("data or select moved under strobe");
	update_gate_a: assert property ($fell(update_all_n) |-> loaded == 4'hf)
		else $error("update before all channels loaded");
	msb_fix_a: assert property (wr_valid && wr_ready |=>
		data_out == ($past(wr_sample) ^ {$past(twos_comp), 11'h0}))
		else $error("wrong code on data lines");
endmodule
bind qdl_host qdl_host_properties u_props (.ref_clk, .rst_b, .twos_comp, .wr_valid, .wr_ready,
	.wr_sample, .loaded, .channel_select_n, .update_all_n, .wr_n, .data_out);
`default_nettype wire

// ==== verification/qdl_dev_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module qdl_dev_model (
	input wire logic reset_n,
	input wire logic wr_n,
	input wire logic update_all_n,
	input wire logic [3:0] channel_select_n,
	input wire logic [11:0] code,
	output logic [11:0] dac_q [4]
);
	logic [11:0] in_q [4];
	// plain latches: both ranks open together when all controls are low
	always @* begin
		for (int i = 0; i < 4; i++) begin
			if (!wr_n && !channel_select_n[i]) in_q[i] = code;
			if (!reset_n) dac_q[i] = 12'h800;
			else if (!wr_n && !update_all_n) dac_q[i] = in_q[i];
		end
	end
endmodule
`default_nettype wire

// ==== verification/qdl_host_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module qdl_host_tb;
	logic ref_clk = 0, rst_b = 0, twos_comp = 0, wr_valid = 0, upd_valid = 0, dev_reset_req = 0;
	logic [1:0] wr_chan = 0;
	logic [11:0] wr_sample = 0;
	logic wr_ready, upd_ready, dev_reset_n, update_all_n, wr_n;
	logic [3:0] loaded, channel_select_n;
	logic [11:0] data_out;
	logic [11:0] dac_q [4];
	int num_errors = 0, checked = 0;
	qdl_host DUT (.ref_clk, .rst_b, .twos_comp, .wr_valid, .wr_ready, .wr_chan, .wr_sample,
		.upd_valid, .upd_ready, .dev_reset_req, .dev_reset_n, .loaded, .channel_select_n,
		.update_all_n, .wr_n, .data_out);
	qdl_dev_model M (.reset_n(dev_reset_n), .wr_n, .update_all_n, .channel_select_n,
		.code(data_out), .dac_q);
	initial forever #2 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	task chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one request, then sit out the 19-cycle busy span with a 20-cycle wait
	task go(input logic w, u, r, tc, input logic [1:0] ch, input logic [11:0] s);
		@(posedge ref_clk);
		#1 {wr_valid, upd_valid, dev_reset_req, twos_comp, wr_chan, wr_sample} = {w, u, r, tc, ch, s};
		@(posedge ref_clk);
		#1 {wr_valid, upd_valid, dev_reset_req} = 3'h0;
		repeat (20) @(posedge ref_clk);
	endtask
	function automatic logic [11:0] ex(int i);
		return (12'h7ff + 12'(i)) ^ {i[0], 11'h0};
	endfunction
	task t_zero;
		for (int i = 0; i < 4; i++) chk(dac_q[i], 12'h800);
	endtask
	task t_refuse;
		go(0, 1, 0, 0, 0, 0);
		chk({11'h0, upd_ready}, 12'h000);
		for (int i = 0; i < 4; i++) chk(dac_q[i], 12'h800);
	endtask
	task t_write;
		for (int i = 0; i < 4; i++) begin
			go(1, 0, 0, i[0], i[1:0], 12'h7ff + 12'(i));
			chk(M.in_q[i], ex(i));
			chk(dac_q[i], 12'h800);
		end
	endtask
	task t_update;
		chk({11'h0, upd_ready}, 12'h001);
		go(0, 1, 0, 0, 0, 0);
		for (int i = 0; i < 4; i++) chk(dac_q[i], ex(i));
	endtask
	task t_devrst;
		go(0, 0, 1, 0, 0, 0);
		for (int i = 0; i < 4; i++) chk(dac_q[i], 12'h800);
		chk({8'h0, loaded}, 12'h0);
		t_refuse();
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1;
		repeat (3) @(posedge ref_clk);
		t_zero();
		t_refuse();
		t_write();
		t_update();
		t_devrst();
		results();
	end
	// whole run is under 250 cycles
	initial begin
		#5000;
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
